/* rtl/pbc_defs.svh */
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH

// clock rate and times
`define PBC_CLK_MHZ        40
`define PBC_DEB_SHORT_US   31250
`define PBC_DEB_MID_US     125000
`define PBC_DEB_LONG_US    750000
`define PBC_HOLD_OFF_US    4000000

// register offsets
`define PBC_ADDR_CTRL      8'h00
`define PBC_ADDR_STATUS    8'h04
`define PBC_ADDR_INT_STAT  8'h08
`define PBC_ADDR_INT_CLR   8'h0c
`define PBC_ADDR_INT_MASK  8'h10

// control fields
`define PBC_CTRL_MODE      0
`define PBC_CTRL_LPE       1
`define PBC_CTRL_DBNC_LO   2
`define PBC_CTRL_DBNC_HI   3
`define PBC_CTRL_SLEEP     4

// status fields
`define PBC_STAT_STATE_LO  0
`define PBC_STAT_STATE_HI  1
`define PBC_STAT_DEB       2
`define PBC_STAT_RAW       3

// interrupt flag fields
`define PBC_INT_FALL       0
`define PBC_INT_RISE       1

// reset values
`define PBC_RST_MODE       1'b1
`define PBC_RST_LPE        1'b1
`define PBC_RST_DBNC       2'h0
`define PBC_RST_SLEEP      1'b0
`define PBC_RST_MASK       2'h3
`define PBC_RST_FLAGS      2'h0
`define PBC_RST_PIN        1'b1

// debounce select codes
`define PBC_DBNC_31A       2'h0
`define PBC_DBNC_31B       2'h1
`define PBC_DBNC_125       2'h2
`define PBC_DBNC_750       2'h3

`endif

/* rtl/pbc_pkg.sv */
package pbc_pkg;
   typedef enum logic [1:0] {
      PBC_OFF     = 2'b00,
      PBC_SLEEP   = 2'b01,
      PBC_RUN     = 2'b10,
      PBC_STANDBY = 2'b11
   } pbc_state_t;
endpackage

/* rtl/pbc_hold_timer.sv */
`timescale 1ns/1ps
module pbc_hold_timer #(
   parameter int unsigned W = 28
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         run,
   input  wire logic [W-1:0] limit,
   output logic              reached
);
   logic [W-1:0] cnt_q;

   // saturates at the limit so reached stays high while run holds
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (!run) begin
         cnt_q <= '0;
      end else if (cnt_q < limit) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   assign reached = run & (cnt_q >= limit);
endmodule // pbc_hold_timer

/* rtl/pbc_power_button.sv */
// Overview of operation
// - With the mode bit at 0 a high input requests run and a low input requests off or sleep.
// - With the mode bit at 1 a qualified falling edge of the input requests power on.
// - In edge mode a low held at least 4.0 s with long-press-off enabled requests off or sleep.
// - In edge mode a short low pulse while off or asleep moves the device to run.
// - In edge mode a short low pulse in run or standby changes no state and only interrupts.
// - Each debounced falling edge and each debounced rising edge sets a button flag.
// - The default debounce is 31.25 ms on both falling and rising edges.
// - Debounce codes 00/01 give 31.25 ms, 10 gives 125 ms, 11 gives 750 ms on the falling edge.
// - A flag stays set until software clears it or the device passes through off.
// - The active-low interrupt is asserted while an unmasked flag is set; write 1 clears.
// - All mask bits are set at reset and unmasking a set flag asserts the interrupt.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pbc_defs.svh"
module pbc_power_button #(
   parameter int unsigned CNT_W         = 28,
   parameter int unsigned DEB_SHORT_CYC = `PBC_DEB_SHORT_US * `PBC_CLK_MHZ,
   parameter int unsigned DEB_MID_CYC   = `PBC_DEB_MID_US * `PBC_CLK_MHZ,
   parameter int unsigned DEB_LONG_CYC  = `PBC_DEB_LONG_US * `PBC_CLK_MHZ,
   parameter int unsigned HOLD_OFF_CYC  = `PBC_HOLD_OFF_US * `PBC_CLK_MHZ
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           power_button_input,
   input  wire logic           standby_request,
   input  wire logic [7:0]     reg_addr,
   input  wire logic [7:0]     reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic [7:0]          reg_rdata,
   output logic                interrupt_request_out_n,
   output pbc_pkg::pbc_state_t power_state
);
   import pbc_pkg::*;

   logic             sync1_q;
   logic             sync2_q;
   logic             deb_q;
   logic             deb_done;
   logic             long_done;
   logic             long_fired_q;
   logic             long_act;
   logic             fall_evt;
   logic             rise_evt;
   logic             button_mode_select_q;
   logic             long_press_off_enable_q;
   logic [1:0]       button_debounce_select_q;
   logic             sleep_target_q;
   logic [1:0]       mask_q;
   logic [1:0]       flag_q;
   logic [1:0]       flag_d;
   logic [1:0]       clr_bits;
   logic             off_entry;
   logic [CNT_W-1:0] fall_lim;
   logic [CNT_W-1:0] deb_lim;
   logic [CNT_W-1:0] rise_run_q;
   pbc_state_t       state_q;
   pbc_state_t       state_d;
   pbc_state_t       off_tgt;
   logic [7:0]       rd_val;

   // two flops, the first read only by the second
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_q <= `PBC_RST_PIN;
         sync2_q <= `PBC_RST_PIN;
      end else begin
         sync1_q <= power_button_input;
         sync2_q <= sync1_q;
      end
   end

   // configuration register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         button_mode_select_q     <= `PBC_RST_MODE;
         long_press_off_enable_q  <= `PBC_RST_LPE;
         button_debounce_select_q <= `PBC_RST_DBNC;
         sleep_target_q           <= `PBC_RST_SLEEP;
      end else if (reg_wr && reg_addr == `PBC_ADDR_CTRL) begin
         button_mode_select_q     <= reg_wdata[`PBC_CTRL_MODE];
         long_press_off_enable_q  <= reg_wdata[`PBC_CTRL_LPE];
         button_debounce_select_q <= reg_wdata[`PBC_CTRL_DBNC_HI:`PBC_CTRL_DBNC_LO];
         sleep_target_q           <= reg_wdata[`PBC_CTRL_SLEEP];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask_q <= `PBC_RST_MASK;
      end else if (reg_wr && reg_addr == `PBC_ADDR_INT_MASK) begin
         mask_q <= reg_wdata[1:0];
      end
   end

   // falling-edge debounce from the select; rising edge always short
   always_comb begin
      case (button_debounce_select_q)
         `PBC_DBNC_31A: fall_lim = CNT_W'(DEB_SHORT_CYC - 1);
         `PBC_DBNC_31B: fall_lim = CNT_W'(DEB_SHORT_CYC - 1);
         `PBC_DBNC_125: fall_lim = CNT_W'(DEB_MID_CYC - 1);
         `PBC_DBNC_750: fall_lim = CNT_W'(DEB_LONG_CYC - 1);
      endcase
      deb_lim = sync2_q ? CNT_W'(DEB_SHORT_CYC - 1) : fall_lim;
   end

   pbc_hold_timer #(
      .W       (CNT_W)
   ) u_deb (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (sync2_q != deb_q),
      .limit   (deb_lim),
      .reached (deb_done)
   );

   // any bounce back to the debounced level restarts the timer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         deb_q <= `PBC_RST_PIN;
      end else if (deb_done) begin
         deb_q <= sync2_q;
      end
   end

   assign fall_evt = deb_done & ~sync2_q;
   assign rise_evt = deb_done & sync2_q;

   // long hold counts on the synchronized level, not the debounced one
   pbc_hold_timer #(
      .W       (CNT_W)
   ) u_long (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (button_mode_select_q & ~sync2_q),
      .limit   (CNT_W'(HOLD_OFF_CYC - 1)),
      .reached (long_done)
   );

   // one shot per hold, so a held button does not retrigger
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         long_fired_q <= 1'b0;
      end else if (sync2_q || !button_mode_select_q) begin
         long_fired_q <= 1'b0;
      end else if (long_done) begin
         long_fired_q <= 1'b1;
      end
   end

   assign long_act = long_done & ~long_fired_q & long_press_off_enable_q
                     & button_mode_select_q;

   assign off_tgt = sleep_target_q ? PBC_SLEEP : PBC_OFF;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         PBC_OFF, PBC_SLEEP: begin
            if (button_mode_select_q ? fall_evt : sync2_q) begin
               state_d = PBC_RUN;
            end
         end
         PBC_RUN: begin
            // in edge mode a short press here only raises the flag
            if ((!button_mode_select_q && !sync2_q) || long_act) begin
               state_d = off_tgt;
            end else if (standby_request) begin
               state_d = PBC_STANDBY;
            end
         end
         PBC_STANDBY: begin
            if ((!button_mode_select_q && !sync2_q) || long_act) begin
               state_d = off_tgt;
            end else if (!standby_request) begin
               state_d = PBC_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q <= PBC_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   assign power_state = state_q;

   // new events win over a clear or an off entry in the same cycle
   assign off_entry = (state_d == PBC_OFF) && (state_q != PBC_OFF);
   assign clr_bits  = (reg_wr && reg_addr == `PBC_ADDR_INT_CLR) ? reg_wdata[1:0] : 2'h0;
   assign flag_d    = (flag_q & ~clr_bits & {2{~off_entry}}) | {rise_evt, fall_evt};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flag_q <= `PBC_RST_FLAGS;
      end else begin
         flag_q <= flag_d;
      end
   end

   // one cycle behind the flags, kept on a flop for a clean pin
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         interrupt_request_out_n <= 1'b1;
      end else begin
         interrupt_request_out_n <= ~|(flag_q & ~mask_q);
      end
   end

   always_comb begin
      rd_val = 8'h00;
      case (reg_addr)
         `PBC_ADDR_CTRL: begin
            rd_val[`PBC_CTRL_MODE]                     = button_mode_select_q;
            rd_val[`PBC_CTRL_LPE]                      = long_press_off_enable_q;
            rd_val[`PBC_CTRL_DBNC_HI:`PBC_CTRL_DBNC_LO] = button_debounce_select_q;
            rd_val[`PBC_CTRL_SLEEP]                    = sleep_target_q;
         end
         `PBC_ADDR_STATUS: begin
            rd_val[`PBC_STAT_STATE_HI:`PBC_STAT_STATE_LO] = state_q;
            rd_val[`PBC_STAT_DEB]                         = deb_q;
            rd_val[`PBC_STAT_RAW]                         = sync2_q;
         end
         `PBC_ADDR_INT_STAT: rd_val[1:0] = flag_q;
         `PBC_ADDR_INT_MASK: rd_val[1:0] = mask_q;
         default:            rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rd ? rd_val : 8'h00;
      end
   end

   // checker aid: cycles the synced level has stood high over a low debounced level
   always_ff @(posedge clk) begin
      if (!rst_n || !sync2_q || deb_q) begin
         rise_run_q <= '0;
      end else begin
         rise_run_q <= rise_run_q + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence seq_low_state;
      (state_q == PBC_OFF) || (state_q == PBC_SLEEP);
   endsequence

   sequence seq_edge_wake;
      (button_mode_select_q && fall_evt) ##0 seq_low_state;
   endsequence

   sequence seq_edge_tap_on;
      button_mode_select_q && fall_evt && !long_act
      && ((state_q == PBC_RUN) || (state_q == PBC_STANDBY));
   endsequence

   chk_level_on: assert property (
      (!button_mode_select_q && sync2_q) ##0 seq_low_state |=> state_q == PBC_RUN)
      else $error("level high did not turn on");

   chk_level_off: assert property (
      (!button_mode_select_q && !sync2_q && state_q == PBC_RUN)
      |=> (state_q == $past(off_tgt)))
      else $error("level low did not turn off");

   chk_edge_wake: assert property (
      seq_edge_wake |=> state_q == PBC_RUN)
      else $error("edge press did not wake");

   chk_edge_only_wake: assert property (
      (button_mode_select_q ##0 seq_low_state ##1 state_q == PBC_RUN) |-> $past(fall_evt))
      else $error("edge mode woke without a falling edge");

   chk_tap_no_change: assert property (
      seq_edge_tap_on |=> (state_q == PBC_RUN) || (state_q == PBC_STANDBY))
      else $error("short press changed state");

   chk_long_needs_en: assert property (
      (button_mode_select_q && state_q == PBC_RUN ##1 state_q != PBC_RUN
       && state_q != PBC_STANDBY) |-> $past(long_press_off_enable_q) && $past(long_done))
      else $error("edge mode left run without enabled long hold");

   chk_flag_set: assert property (
      (fall_evt || rise_evt) |=> (flag_q != 2'h0))
      else $error("edge did not set flag");

   chk_rise_short: assert property (
      rise_evt |-> rise_run_q == CNT_W'(DEB_SHORT_CYC - 1))
      else $error("rise debounce not at the short length");

   chk_flag_sticky: assert property (
      (flag_q[`PBC_INT_FALL] && !clr_bits[`PBC_INT_FALL] && !off_entry)
      |=> flag_q[`PBC_INT_FALL])
      else $error("flag dropped without clear");

   chk_off_clears: assert property (
      (off_entry && !fall_evt && !rise_evt) |=> flag_q == 2'h0)
      else $error("off entry left a flag set");

   chk_irq_out: assert property (
      (|(flag_q & ~mask_q)) |=> !interrupt_request_out_n)
      else $error("unmasked flag did not assert interrupt");

   chk_irq_masked: assert property (
      (!(|(flag_q & ~mask_q)))[*2] |-> interrupt_request_out_n)
      else $error("interrupt asserted with nothing unmasked");
endmodule // pbc_power_button

/* tb/pbc_button_model.sv */
`timescale 1ns/1ps
module pbc_button_model (
   input  wire logic clk,
   output logic      level
);
   // push-button with pull-up: idle high, low while pressed
   initial level = 1'b1;
   task automatic set(input logic v);
      @(posedge clk);
      level <= v;
   endtask
   task automatic press(input int n);
      set(1'b0);
      repeat (n - 1) @(posedge clk);
      level <= 1'b1;
   endtask
endmodule // pbc_button_model

/* tb/tb.sv */
`timescale 1ns/1ps
`include "pbc_defs.svh"
module tb;
   import pbc_pkg::*;
   logic       clk;
   logic       rst_n;
   logic       standby_request;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       irq_n;
   logic       button_level;
   pbc_state_t power_state;
   int         err_total;
   int         tests_run;

   pbc_button_model btn (
      .clk   (clk),
      .level (button_level)
   );
   // short counts keep the run small; the order of the timings is kept
   pbc_power_button #(
      .DEB_SHORT_CYC (8),
      .DEB_MID_CYC   (16),
      .DEB_LONG_CYC  (24),
      .HOLD_OFF_CYC  (64)
   ) dut (
      .clk                     (clk),
      .rst_n                   (rst_n),
      .power_button_input      (button_level),
      .standby_request         (standby_request),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .interrupt_request_out_n (irq_n),
      .power_state             (power_state)
   );

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      cmp($sformatf("reg %h", a), exp, reg_rdata);
   endtask
   task automatic look(input logic [1:0] st, input logic irq);
      #1;
      cmp("state", {6'h0, st}, {6'h0, power_state});
      cmp("irq", {7'h0, irq}, {7'h0, irq_n});
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic conclude;
      $display("mismatches %0d of %0d checks", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      err_total = 0;
      tests_run = 0;
      rst_n = 1'b0;
      standby_request = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(`PBC_ADDR_CTRL, 8'h03);
      rd(`PBC_ADDR_INT_MASK, 8'h03);
      rd(`PBC_ADDR_STATUS, 8'h0c);
      look(PBC_OFF, 1'b1);
      btn.press(14);
      idle(40);
      look(PBC_RUN, 1'b1);
      rd(`PBC_ADDR_INT_STAT, 8'h03);
      wr(`PBC_ADDR_INT_MASK, 8'h00);
      idle(3);
      look(PBC_RUN, 1'b0);
      wr(`PBC_ADDR_INT_CLR, 8'h01);
      idle(3);
      rd(`PBC_ADDR_INT_STAT, 8'h02);
      look(PBC_RUN, 1'b0);
      wr(`PBC_ADDR_INT_CLR, 8'h02);
      idle(3);
      look(PBC_RUN, 1'b1);
      // 14-cycle press clears the short filter only
      for (int c = 0; c < 4; c++) begin
         wr(`PBC_ADDR_CTRL, {4'h0, c[1:0], 2'h3});
         btn.press(14);
         idle(40);
         look(PBC_RUN, (c < 2) ? 1'b0 : 1'b1);
         rd(`PBC_ADDR_INT_STAT, (c < 2) ? 8'h03 : 8'h00);
         wr(`PBC_ADDR_INT_CLR, 8'h03);
      end
      // long fall filter, rise flag must still come quickly
      btn.press(40);
      idle(14);
      rd(`PBC_ADDR_INT_STAT, 8'h03);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      @(posedge clk);
      standby_request <= 1'b1;
      idle(5);
      look(PBC_STANDBY, 1'b1);
      // back to the short filter so the tap below qualifies
      wr(`PBC_ADDR_CTRL, 8'h03);
      btn.press(14);
      idle(40);
      look(PBC_STANDBY, 1'b0);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      standby_request <= 1'b0;
      idle(5);
      look(PBC_RUN, 1'b1);
      wr(`PBC_ADDR_CTRL, 8'h13);
      btn.press(100);
      idle(40);
      look(PBC_SLEEP, 1'b0);
      rd(`PBC_ADDR_INT_STAT, 8'h03);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      btn.press(14);
      idle(40);
      look(PBC_RUN, 1'b0);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      wr(`PBC_ADDR_CTRL, 8'h03);
      btn.press(100);
      idle(40);
      look(PBC_OFF, 1'b0);
      rd(`PBC_ADDR_INT_STAT, 8'h02);
      wr(`PBC_ADDR_CTRL, 8'h01);
      btn.press(14);
      idle(40);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      btn.press(100);
      idle(40);
      look(PBC_RUN, 1'b0);
      wr(`PBC_ADDR_INT_CLR, 8'h03);
      wr(`PBC_ADDR_CTRL, 8'h02);
      btn.set(1'b0);
      idle(40);
      look(PBC_OFF, 1'b0);
      btn.set(1'b1);
      idle(40);
      look(PBC_RUN, 1'b0);
      rd(8'h20, 8'h00);
      wr(`PBC_ADDR_STATUS, 8'hff);
      rd(`PBC_ADDR_STATUS, 8'h0e);
      conclude();
   end

   // whole sequence needs about 1100 cycles
   initial begin
      idle(20000);
      err_total++;
      conclude();
   end
endmodule // tb
